// ---- logic/psr_defines.vh ----
/*
 routing selector constants: offsets, fields, reset values.
 assumes inclusion by bare name from the design files.
*/
`ifndef PSR_DEFINES_VH
`define PSR_DEFINES_VH
`define PSR_OFF_SEL0        12'h000
`define PSR_OFF_SEL1        12'h004
`define PSR_SEL0_MASK       8'h3f
`define PSR_SEL1_MASK       8'h0f
`define PSR_SEL_RESET       8'h00
`define PSR_BIT_SS_OVR      5
`define PSR_BIT_SPI_SET     4
`define PSR_BIT_SER1        3
`define PSR_BIT_PWM_PROBE   3
`define PSR_BIT_PWM45       2
`define PSR_BIT_PWM23       1
`define PSR_BIT_PWM01       0
`define PSR_MODE_DIRECT     3'h0
`define PSR_MODE_LPDR       3'h1
`define PSR_MODE_PROBE      3'h4
`define PSR_MODE_CONF       3'h6
`endif

// ---- logic/psr_sync2.v ----
/*
 two flip-flop synchroniser for one pin level.
 assumes din is asynchronous to clk.
*/
`timescale 1ns/100ps
`include "psr_defines.vh"
module psr_sync2 (
   input  wire clk,
   input  wire rst_n,
   input  wire din,
   output reg  dout
);
   reg meta_r;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= 1'b0;
         dout   <= 1'b0;
      end else begin
         meta_r <= din;
         dout   <= meta_r;
      end
   end
endmodule

// ---- logic/psr_lock_reg.v ----
/*
 write-once selector register with special-mode override.
 assumes wr_en is a single-cycle apb write strobe.
*/
`timescale 1ns/100ps
`include "psr_defines.vh"
module psr_lock_reg (
   input  wire       clk,
   input  wire       rst_n,
   input  wire       wr_en,
   input  wire       special_mode,
   input  wire [7:0] wdata,
   input  wire [7:0] mask,
   output reg  [7:0] q_r
);
   reg locked_r;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q_r      <= `PSR_SEL_RESET;
         locked_r <= 1'b0;
      end else if (wr_en && (special_mode || !locked_r)) begin
         q_r      <= wdata & mask;
         locked_r <= 1'b1;
      end
   end
endmodule

// ---- logic/psr_top.v ----
/*
 peripheral signal routing: apb selector registers and pin routing.
 assumes pins arrive asynchronous; peripheral signals share pclk.
*/
// The implementer's own choices: the placing of the registers and the APB register port.
// Notes on behaviour
// - selectors read anytime, write once in normal mode, anytime special.
// - slave-select override sends slave select to analog pin 6 instead of its own pin.
// - pin-set bit moves spi to timer pins 0-3 else serial pins 2-5.
// - serial port one uses pins 1/0 when clear; when set it receives on pin 2 and enables pin 3 driven low.
// - a three-bit field picks the serial zero to lin routing mode.
// - mode 000 links serial zero to the lin transceiver, internal only.
// - mode 001 drives lin transmit from the lin direct bit.
// - mode 100 keeps the link and shows it on two pins.
// - mode 110 opens the link and routes all four signals to pins.
// - transmit pin routing needs serial zero on, lin pins need lin on.
// - probe bit connects all six pwm outputs to their pwm pins.
// - pair 4/5 bit sends pwm4/5 to timer pins 1/2, gate inputs low.
// - pair 2/3 bit sends pwm2/3 to power pin 2 and timer pin 0.
// - pair 0/1 bit sends pwm0/1 to power pins 0/1, gate inputs low.
// - reserved bits ignore writes and read as zero.
`timescale 1ns/100ps
`include "psr_defines.vh"
module psr_top (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        special_mode,
   input  wire        spi_miso_pin_t0,
   input  wire        spi_miso_pin_s2,
   input  wire        spi_mosi,
   input  wire        spi_sck,
   input  wire        spi_ss,
   input  wire        spi_oe,
   output reg  [6:0]  spi_pin_out,
   output reg  [6:0]  spi_pin_oe,
   output reg         spi_miso,
   input  wire        serial_one_transmit,
   input  wire        serial_one_rx_pin0,
   input  wire        serial_one_rx_pin2,
   output reg  [1:0]  ser1_pin_out,
   output reg  [1:0]  ser1_pin_oe,
   output reg         serial_one_receive,
   input  wire        serial_zero_transmit,
   input  wire        serial_zero_enable,
   input  wire        lin_phy_receive_out,
   input  wire        lin_phy_dominant_ctrl,
   input  wire        lin_transceiver_enable,
   input  wire        lin_direct_tx_bit,
   input  wire        serial_zero_rx_pin,
   input  wire        lin_tx_pin,
   output reg         serial_zero_receive,
   output reg         lin_phy_transmit_in,
   output reg  [3:0]  lin_pin_out,
   output reg  [3:0]  lin_pin_oe,
   input  wire [5:0]  pwm_in,
   output reg  [5:0]  pwm_probe_out,
   output reg  [5:0]  pwm_probe_oe,
   output reg  [5:0]  pwm_route_out,
   output reg  [5:0]  pwm_route_oe,
   output reg  [5:0]  gate_driver_in
);
   wire [7:0] sel0_r;
   wire [7:0] sel1_r;
   wire       miso_t0_s;
   wire       miso_s2_s;
   wire       rx1_p0_s;
   wire       rx1_p2_s;
   wire       rx0_s;
   wire       ltx_s;
   wire       setup;
   wire       wr0;
   wire       wr1;
   reg [31:0] prdata_nxt;
   reg [6:0]  spo_nxt;
   reg [6:0]  spe_nxt;
   reg [3:0]  lpo_nxt;
   reg [3:0]  lpe_nxt;
   reg        ltx_nxt;
   reg        rx0_nxt;
   wire [2:0] mode;

   function hit;
      input [11:0] a;
      input [11:0] off;
      begin
         hit = (a == off);
      end
   endfunction

   psr_sync2 u_s0 (.clk(pclk), .rst_n(presetn), .din(spi_miso_pin_t0),
                   .dout(miso_t0_s));
   psr_sync2 u_s1 (.clk(pclk), .rst_n(presetn), .din(spi_miso_pin_s2),
                   .dout(miso_s2_s));
   psr_sync2 u_s2 (.clk(pclk), .rst_n(presetn), .din(serial_one_rx_pin0),
                   .dout(rx1_p0_s));
   psr_sync2 u_s3 (.clk(pclk), .rst_n(presetn), .din(serial_one_rx_pin2),
                   .dout(rx1_p2_s));
   psr_sync2 u_s4 (.clk(pclk), .rst_n(presetn), .din(serial_zero_rx_pin),
                   .dout(rx0_s));
   psr_sync2 u_s5 (.clk(pclk), .rst_n(presetn), .din(lin_tx_pin),
                   .dout(ltx_s));

   // apb decode: writes land on setup, answer in access phase
   assign setup = psel && !penable;
   assign wr0   = setup && pwrite && hit(paddr, `PSR_OFF_SEL0);
   assign wr1   = setup && pwrite && hit(paddr, `PSR_OFF_SEL1);

   psr_lock_reg u_sel0 (
      .clk          (pclk),
      .rst_n        (presetn),
      .wr_en        (wr0),
      .special_mode (special_mode),
      .wdata        (pwdata[7:0]),
      .mask         (`PSR_SEL0_MASK),
      .q_r          (sel0_r)
   );
   psr_lock_reg u_sel1 (
      .clk          (pclk),
      .rst_n        (presetn),
      .wr_en        (wr1),
      .special_mode (special_mode),
      .wdata        (pwdata[7:0]),
      .mask         (`PSR_SEL1_MASK),
      .q_r          (sel1_r)
   );

   always @* begin
      prdata_nxt = 32'h0000_0000;
      if (hit(paddr, `PSR_OFF_SEL0)) begin
         prdata_nxt = {24'h00_0000, sel0_r};
      end else if (hit(paddr, `PSR_OFF_SEL1)) begin
         prdata_nxt = {24'h00_0000, sel1_r};
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup;
         pslverr <= setup && !hit(paddr, `PSR_OFF_SEL0)
                    && !hit(paddr, `PSR_OFF_SEL1);
         if (setup && !pwrite) begin
            prdata <= prdata_nxt;
         end
      end
   end

   // spi pins: [0..3] timer pins 0-3, [4..6] serial pins 3-5
   // layout: 0 t0 miso,1 t1 mosi,2 t2 sck,3 t3 ss,
   //         4 s3 mosi,5 s4 sck,6 slave select on s5; the analog_port_pin6 override drives index 0
   always @* begin
      spo_nxt = 7'h00;
      spe_nxt = 7'h00;
      if (sel0_r[`PSR_BIT_SPI_SET]) begin
         spo_nxt[1] = spi_mosi;
         spo_nxt[2] = spi_sck;
         spe_nxt[1] = spi_oe;
         spe_nxt[2] = spi_oe;
         spo_nxt[3] = spi_ss;
         spe_nxt[3] = !sel0_r[`PSR_BIT_SS_OVR];
      end else begin
         spo_nxt[4] = spi_mosi;
         spo_nxt[5] = spi_sck;
         spe_nxt[4] = spi_oe;
         spe_nxt[5] = spi_oe;
         spo_nxt[6] = spi_ss;
         spe_nxt[6] = !sel0_r[`PSR_BIT_SS_OVR];
      end
      if (sel0_r[`PSR_BIT_SS_OVR]) begin
         spo_nxt[0] = spi_ss;
         spe_nxt[0] = 1'b1;
      end
   end

   assign mode = sel0_r[2:0];

   // lin pins: 0 timer pin1 tx0, 1 timer pin0 lin rx,
   //           2 serial pin0 lin dc, 3 serial pin1 tx probe
   always @* begin
      ltx_nxt = serial_zero_transmit;
      rx0_nxt = lin_phy_receive_out;
      lpo_nxt = 4'h0;
      lpe_nxt = 4'h0;
      case (mode)
         `PSR_MODE_LPDR: begin
            ltx_nxt = lin_direct_tx_bit;
         end
         `PSR_MODE_PROBE: begin
            lpo_nxt[3] = serial_zero_transmit;
            lpe_nxt[3] = serial_zero_enable;
            lpo_nxt[2] = lin_phy_receive_out;
            lpe_nxt[2] = lin_transceiver_enable;
         end
         `PSR_MODE_CONF: begin
            ltx_nxt = ltx_s;
            rx0_nxt = rx0_s;
            lpo_nxt[0] = serial_zero_transmit;
            lpe_nxt[0] = serial_zero_enable;
            lpo_nxt[1] = lin_phy_receive_out;
            lpe_nxt[1] = lin_transceiver_enable;
            lpo_nxt[2] = lin_phy_dominant_ctrl;
            lpe_nxt[2] = lin_transceiver_enable;
         end
         default: begin
            ltx_nxt = serial_zero_transmit;
         end
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         spi_pin_out         <= 7'h00;
         spi_pin_oe          <= 7'h00;
         spi_miso            <= 1'b0;
         ser1_pin_out        <= 2'h0;
         ser1_pin_oe         <= 2'h0;
         serial_one_receive  <= 1'b1;
         serial_zero_receive <= 1'b1;
         lin_phy_transmit_in <= 1'b1;
         lin_pin_out         <= 4'h0;
         lin_pin_oe          <= 4'h0;
         pwm_probe_out       <= 6'h00;
         pwm_probe_oe        <= 6'h00;
         pwm_route_out       <= 6'h00;
         pwm_route_oe        <= 6'h00;
         gate_driver_in      <= 6'h00;
      end else begin
         spi_pin_out <= spo_nxt;
         spi_pin_oe  <= spe_nxt;
         spi_miso    <= sel0_r[`PSR_BIT_SPI_SET] ? miso_t0_s
                                                 : miso_s2_s;
         // ser1 pins: [0] pin1 transmit, [1] pin3 driven low
         ser1_pin_out <= {1'b0, serial_one_transmit};
         ser1_pin_oe  <= sel0_r[`PSR_BIT_SER1] ? 2'h2 : 2'h1;
         serial_one_receive <= sel0_r[`PSR_BIT_SER1] ? rx1_p2_s
                                                     : rx1_p0_s;
         serial_zero_receive <= rx0_nxt;
         lin_phy_transmit_in <= ltx_nxt;
         lin_pin_out <= lpo_nxt;
         lin_pin_oe  <= lpe_nxt;
         pwm_probe_out <= pwm_in;
         pwm_probe_oe  <= {6{sel1_r[`PSR_BIT_PWM_PROBE]}};
         // route order: 0 pp0,1 pp1,2 pp2,3 pt0,4 pt1,5 pt2
         pwm_route_out <= pwm_in;
         pwm_route_oe  <= {{2{sel1_r[`PSR_BIT_PWM45]}},
                           {2{sel1_r[`PSR_BIT_PWM23]}},
                           {2{sel1_r[`PSR_BIT_PWM01]}}};
         gate_driver_in <= pwm_in & ~{{2{sel1_r[`PSR_BIT_PWM45]}},
                                      {2{sel1_r[`PSR_BIT_PWM23]}},
                                      {2{sel1_r[`PSR_BIT_PWM01]}}};
      end
   end
endmodule

// ---- verif/psr_partner.sv ----
/*
 peripheral and pin side levels for psr_top.
 assumes the bench sets lv just after a rising pclk edge.
*/
`timescale 1ns/100ps
module psr_partner (
   input  wire [20:0] lv,
   output wire [5:0]  pwm_in,
   output wire        lin_tx_pin,
   output wire        serial_zero_rx_pin,
   output wire        lin_direct_tx_bit,
   output wire        lin_phy_dominant_ctrl,
   output wire        lin_phy_receive_out,
   output wire        serial_zero_transmit,
   output wire        serial_one_rx_pin2,
   output wire        serial_one_rx_pin0,
   output wire        serial_one_transmit,
   output wire        spi_oe,
   output wire        spi_ss,
   output wire        spi_sck,
   output wire        spi_mosi,
   output wire        spi_miso_pin_s2,
   output wire        spi_miso_pin_t0
);
   // each level is one bit of lv, except pwm_in which takes the top six
   assign {pwm_in, lin_tx_pin, serial_zero_rx_pin, lin_direct_tx_bit,
           lin_phy_dominant_ctrl, lin_phy_receive_out, serial_zero_transmit,
           serial_one_rx_pin2, serial_one_rx_pin0, serial_one_transmit,
           spi_oe, spi_ss, spi_sck, spi_mosi, spi_miso_pin_s2,
           spi_miso_pin_t0} = lv;
endmodule

// ---- verif/psr_chk.sv ----
/*
 concurrent checks on the psr_top ports.
 assumes a bind onto psr_top, one clock, async low reset.
*/
`timescale 1ns/100ps
module psr_chk (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        serial_zero_enable,
   input wire        lin_transceiver_enable,
   input wire [6:0]  spi_pin_oe,
   input wire [1:0]  ser1_pin_oe,
   input wire [3:0]  lin_pin_oe,
   input wire [5:0]  pwm_in,
   input wire [5:0]  pwm_probe_out,
   input wire [5:0]  pwm_probe_oe,
   input wire [5:0]  pwm_route_oe,
   input wire [5:0]  gate_driver_in
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_setup; psel && !penable; endsequence
   sequence s_answer; pready ##1 !pready; endsequence
   property p_rdy; s_setup |=> s_answer; endproperty
   property p_upper; pready |-> prdata[31:8] == 24'h0; endproperty
   property p_ss; spi_pin_oe[0] |-> spi_pin_oe[6:3] == 4'h0; endproperty
   property p_ser1; ser1_pin_oe != 2'h3; endproperty
   property p_gate;
      (gate_driver_in & pwm_route_oe) == 6'h00 && pwm_route_oe[0]
      == pwm_route_oe[1] && pwm_route_oe[4] == pwm_route_oe[5];
   endproperty
   property p_pass;
      $past(presetn) |-> gate_driver_in == ($past(pwm_in) & ~pwm_route_oe);
   endproperty
   property p_probe;
      $past(presetn) |-> pwm_probe_oe inside {6'h00, 6'h3f} &&
      (pwm_probe_out & pwm_probe_oe) == ($past(pwm_in) & pwm_probe_oe);
   endproperty
   property p_lintx;
      lin_pin_oe[0] || lin_pin_oe[3] |-> $past(serial_zero_enable);
   endproperty
   property p_linrx;
      lin_pin_oe[1] || lin_pin_oe[2] |-> $past(lin_transceiver_enable);
   endproperty
   a_rdy: assert property (p_rdy) else $error("no answer");
   a_upper: assert property (p_upper) else $error("upper bits");
   a_ss: assert property (p_ss) else $error("select twice");
   a_ser1: assert property (p_ser1) else $error("tx twice");
   a_gate: assert property (p_gate) else $error("gate");
   a_pass: assert property (p_pass) else $error("gate data");
   a_probe: assert property (p_probe) else $error("probe");
   a_lintx: assert property (p_lintx) else $error("tx pin");
   a_linrx: assert property (p_linrx) else $error("rx pin");
endmodule

// ---- verif/tb.sv ----
/*
 bench for psr_top: apb master tasks and routing scenarios.
 assumes psr_partner supplies peripheral and pin levels from lv.
*/
`timescale 1ns/100ps
`define CHK(g, x) begin num_checks = num_checks + 1; \
   if ((g) !== (x)) begin mismatches = mismatches + 1; \
   $display("Error t=%0t got %h exp %h", $time, g, x); end end
module tb;
   reg         pclk, presetn, psel, penable, pwrite, special_mode;
   reg         serial_zero_enable, lin_transceiver_enable;
   reg  [11:0] paddr;
   reg  [31:0] pwdata;
   reg  [20:0] lv;
   reg  [32:0] q;
   integer     mismatches, num_checks;
   wire [31:0] prdata;
   wire        pready, pslverr, spi_miso, serial_one_receive;
   wire        serial_zero_receive, lin_phy_transmit_in;
   wire [6:0]  spi_pin_out, spi_pin_oe;
   wire [1:0]  ser1_pin_out, ser1_pin_oe;
   wire [3:0]  lin_pin_out, lin_pin_oe;
   wire [5:0]  pwm_in, pwm_probe_out, pwm_probe_oe;
   wire [5:0]  pwm_route_out, pwm_route_oe, gate_driver_in;
   wire        spi_miso_pin_t0, spi_miso_pin_s2, spi_mosi, spi_sck;
   wire        spi_ss, spi_oe, serial_one_transmit, serial_one_rx_pin0;
   wire        serial_one_rx_pin2, serial_zero_transmit, lin_tx_pin;
   wire        lin_phy_receive_out, lin_phy_dominant_ctrl;
   wire        lin_direct_tx_bit, serial_zero_rx_pin;
   psr_top dut_u (.*);
   psr_partner far_u (.*);
   always #12.5 pclk = ~pclk;
   task apb(input w, input [11:0] a, input [31:0] d);
      integer n;
      begin
         @(posedge pclk);
         psel    <= 1'b1;
         penable <= 1'b0;
         pwrite  <= w;
         paddr   <= a;
         pwdata  <= d;
         @(posedge pclk);
         penable <= 1'b1;
         n = 0;
         do begin
            @(posedge pclk);
            n = n + 1;
         end while (pready !== 1'b1 && n < 16);
         q = {pslverr, prdata};
         psel    <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task t_lock;
      begin
         apb(1'b0, 12'h000, 32'h0);
         `CHK(q, 33'h0)
         apb(1'b1, 12'h004, 32'hffff_fff5);
         apb(1'b1, 12'h004, 32'h0000_000f);
         apb(1'b0, 12'h004, 32'h0);
         `CHK(q, 33'h5)
         `CHK({pwm_route_oe, gate_driver_in}, {6'h33, 6'h0c})
         apb(1'b1, 12'h000, 32'h0);
         apb(1'b1, 12'h000, 32'h30);
         apb(1'b0, 12'h000, 32'h0);
         `CHK(q, 33'h0)
         apb(1'b0, 12'h010, 32'h0);
         `CHK(q, 33'h1_0000_0000)
         $display("t_lock done");
      end
   endtask
   task t_sel0;
      reg [7:0]  v [0:5];
      reg [1:0]  en [0:5];
      reg [16:0] x [0:5];
      reg [16:0] g;
      integer    i;
      begin
         v  = '{8'h30, 8'h19, 8'h1c, 8'h06, 8'h06, 8'h06};
         en = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h2, 2'h1};
         x  = '{{7'h07, 2'h1, 4'h0, 4'h7}, {7'h0e, 2'h2, 4'h0, 4'he},
                {7'h0e, 2'h2, 4'hc, 4'h6}, {7'h70, 2'h0, 4'h7, 4'h8},
                {7'h70, 2'h0, 4'h1, 4'h8}, {7'h70, 2'h0, 4'h6, 4'h8}};
         special_mode <= 1'b1;
         for (i = 0; i < 6; i = i + 1) begin
            serial_zero_enable     <= en[i][1];
            lin_transceiver_enable <= en[i][0];
            apb(1'b1, 12'h000, {24'h0, v[i]});
            apb(1'b0, 12'h000, 32'h0);
            `CHK(q, {25'h0, v[i]})
            g = {spi_pin_oe, ser1_pin_oe, lin_pin_oe, lin_phy_transmit_in,
                 serial_zero_receive, spi_miso, serial_one_receive};
            if (i > 2)
               g = g & {7'h7f, 2'h0, 4'hf, 4'he};
            `CHK(g, x[i])
         end
         $display("t_sel0 done");
      end
   endtask
   task t_sel1;
      reg [7:0] v [0:4];
      reg [5:0] r [0:4];
      reg [5:0] pe;
      integer   i;
      begin
         v = '{8'h08, 8'h02, 8'h04, 8'h01, 8'h0f};
         r = '{6'h00, 6'h0c, 6'h30, 6'h03, 6'h3f};
         for (i = 0; i < 5; i = i + 1) begin
            apb(1'b1, 12'h004, {24'h0, v[i]});
            apb(1'b0, 12'h004, 32'h0);
            pe = {6{v[i][3]}};
            `CHK({pwm_probe_oe, pwm_probe_out & pe}, {pe, pwm_in & pe})
            `CHK(pwm_route_out & r[i], pwm_in & r[i])
            `CHK({pwm_route_oe, gate_driver_in}, {r[i], pwm_in & ~r[i]})
         end
         $display("t_sel1 done");
      end
   endtask
   task t_rst2;
      begin
         special_mode <= 1'b0;
         presetn      <= 1'b0;
         repeat (3) @(posedge pclk);
         presetn <= 1'b1;
         apb(1'b0, 12'h004, 32'h0);
         `CHK(q, 33'h0)
         apb(1'b1, 12'h004, 32'h8);
         apb(1'b1, 12'h004, 32'h1);
         apb(1'b0, 12'h004, 32'h0);
         `CHK(q, 33'h8)
         $display("t_rst2 done");
      end
   endtask
   task stop_test;
      begin
         $display("checks %0d mismatches %0d", num_checks, mismatches);
         if (mismatches == 0 && num_checks > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   initial begin
      #200000;
      mismatches = mismatches + 1;
      stop_test;
   end
   initial begin
      {pclk, presetn, psel, penable, pwrite, special_mode} = 6'h00;
      {serial_zero_enable, lin_transceiver_enable} = 2'h3;
      paddr      = 12'h000;
      pwdata     = 32'h0;
      lv         = {6'h2d, 15'h5cfd};
      mismatches = 0;
      num_checks = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_lock;
      t_sel0;
      t_sel1;
      t_rst2;
      stop_test;
   end
endmodule
bind psr_top psr_chk chk_u (.*);
